// File: logic/sic_pkg.sv
package sic_pkg;
    localparam int NSRC = 6;
    localparam int AW   = 8;

    localparam logic [AW-1:0] TIMER_CTRL_A = 8'h80;
    localparam logic [AW-1:0] SERIAL_A     = 8'h84;
    localparam logic [AW-1:0] TIMER2_A     = 8'h88;
    localparam logic [AW-1:0] ENABLE_A     = 8'ha8;
    localparam logic [AW-1:0] PRIORITY_A   = 8'hb8;
    localparam logic [AW-1:0] EVSTAT_A     = 8'hc0;
    localparam logic [AW-1:0] EVMASK_A     = 8'hc4;

    // timer control layout: per ext input i, select at 2i, flag at 2i+1
    localparam int TC_EDGE0 = 0;
    localparam int TC_PEND0 = 1;
    localparam int TC_STEP  = 2;
    localparam int TC_TF0   = 5;
    localparam int TC_TF1   = 7;
    localparam int SER_RX   = 0;
    localparam int SER_TX   = 1;
    localparam int T2_EXEN  = 3;
    localparam int T2_EXF   = 6;
    localparam int T2_TF    = 7;
    localparam int EN_GLOBAL = 7;

    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [5:0] SRC_RST  = 6'h00;

    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SER  = 4;
    localparam int SRC_TMR2 = 5;

    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
endpackage

// File: logic/sic_pin_fall.sv
`timescale 1ns/1ps
module sic_pin_fall (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      fall
);
    import sic_pkg::*;
    logic prev_q;

    // idle-high reset, so a pin low out of reset is seen as a falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b1;
        end else if (clk_en) begin
            prev_q <= pin;
        end
    end

    assign fall = prev_q & ~pin & clk_en;
endmodule

// File: logic/sic_prio_pick.sv
`timescale 1ns/1ps
module sic_prio_pick #(
    parameter int N = 6
) (
    input  wire logic [N-1:0]         req,
    output logic                      found,
    output logic [$clog2(N)-1:0]      idx
);
    import sic_pkg::*;

    // lowest index is highest in the fixed order
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = ($clog2(N))'(i);
            end
        end
    end
endmodule

// File: logic/sic_ctrl.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module sic_ctrl (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [sic_pkg::AW-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               ext_request_pin_0,
    input  wire logic               ext_request_pin_1,
    input  wire logic               timer2_capture_pin,
    input  wire logic               t0_rollover,
    input  wire logic               t1_rollover,
    input  wire logic               t2_rollover,
    input  wire logic               rx_done,
    input  wire logic               tx_done,
    input  wire logic               vec_taken,
    input  wire logic               svc_return,
    input  wire logic               power_down,
    output logic                    vec_req,
    output logic [15:0]             vec_addr,
    output logic                    vec_high,
    output logic                    wake_up,
    output logic                    irq
);
    import sic_pkg::*;

    localparam int IW = $clog2(NSRC);

    logic [1:0]      ext_edge_select_q;
    logic [1:0]      ext_pending_flag_q;
    logic            timer0_overflow_flag_q;
    logic            timer1_overflow_flag_q;
    logic            receive_done_flag_q;
    logic            transmit_done_flag_q;
    logic            timer2_overflow_flag_q;
    logic            timer2_pin_event_flag_q;
    logic            timer2_pin_enable_q;
    logic [7:0]      enable_mask_q;
    logic [5:0]      priority_level_q;
    logic [NSRC-1:0] ev_status_q;
    logic [NSRC-1:0] ev_mask_q;
    logic [NSRC-1:0] src_prev_q;
    logic [1:0]      in_svc_q;
    logic [IW-1:0]   sel_idx_q;
    logic            vec_req_q;
    logic [15:0]     vec_addr_q;
    logic            vec_high_q;
    logic            wake_q;
    logic            irq_q;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;

    logic [2:0]      pins;
    logic [2:0]      fall;
    logic [1:0]      ext_pin;
    logic            apb_done;
    logic            apb_wr;
    logic            apb_rd;
    logic            wr_tc;
    logic            wr_ser;
    logic            wr_t2;
    logic            take;
    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0] active;
    logic [NSRC-1:0] ev_new;
    logic            hi_found;
    logic            lo_found;
    logic [IW-1:0]   hi_idx;
    logic [IW-1:0]   lo_idx;
    logic            grant;
    logic            grant_high;
    logic [IW-1:0]   grant_idx;
    logic [31:0]     rd_mux;
    logic            rd_hit;

    assign ext_pin = {ext_request_pin_1, ext_request_pin_0};
    assign pins    = {timer2_capture_pin, ext_pin};

    // pins taken as synchronous; one falling-edge catcher per pin
    for (genvar g = 0; g < 3; g++) begin : g_fall
        sic_pin_fall u_fall (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .pin     (pins[g]),
            .fall    (fall[g])
        );
    end

    assign apb_done = psel & penable & pready_q & clk_en;
    assign apb_wr   = apb_done & pwrite;
    assign apb_rd   = apb_done & ~pwrite;
    assign wr_tc    = apb_wr & (paddr == TIMER_CTRL_A);
    assign wr_ser   = apb_wr & (paddr == SERIAL_A);
    assign wr_t2    = apb_wr & (paddr == TIMER2_A);
    assign take     = vec_taken & vec_req_q & clk_en;

    // no idle input: the cpu freezing stalls this logic only through clk_en
    assign src_req[SRC_EXT0] = ext_pending_flag_q[0];
    assign src_req[SRC_EXT1] = ext_pending_flag_q[1];
    assign src_req[SRC_TMR0] = timer0_overflow_flag_q;
    assign src_req[SRC_TMR1] = timer1_overflow_flag_q;
    assign src_req[SRC_SER]  = receive_done_flag_q
                             | transmit_done_flag_q;
    assign src_req[SRC_TMR2] = timer2_overflow_flag_q
                             | timer2_pin_event_flag_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_edge_select_q <= 2'b00;
        end else if (wr_tc) begin
            for (int i = 0; i < 2; i++) begin
                ext_edge_select_q[i] <= pwdata[TC_EDGE0 + TC_STEP*i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pending_flag_q <= 2'b00;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (!ext_edge_select_q[i]) begin
                    // level mode tracks the pin; the requester
                    // must drop it before return
                    ext_pending_flag_q[i] <= ~ext_pin[i];
                end else if (fall[i]) begin
                    ext_pending_flag_q[i] <= 1'b1;
                end else if (take && sel_idx_q == IW'(2*i)) begin
                    ext_pending_flag_q[i] <= 1'b0;
                end else if (wr_tc) begin
                    ext_pending_flag_q[i] <= pwdata[TC_PEND0 + TC_STEP*i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_overflow_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (t0_rollover) begin
                timer0_overflow_flag_q <= 1'b1;
            end else if (take && sel_idx_q == IW'(SRC_TMR0)) begin
                timer0_overflow_flag_q <= 1'b0;
            end else if (wr_tc) begin
                timer0_overflow_flag_q <= pwdata[TC_TF0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer1_overflow_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (t1_rollover) begin
                timer1_overflow_flag_q <= 1'b1;
            end else if (take && sel_idx_q == IW'(SRC_TMR1)) begin
                timer1_overflow_flag_q <= 1'b0;
            end else if (wr_tc) begin
                timer1_overflow_flag_q <= pwdata[TC_TF1];
            end
        end
    end

    // serial flags: only software clears, vector taken leaves them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_done_flag_q  <= 1'b0;
            transmit_done_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_done) begin
                receive_done_flag_q <= 1'b1;
            end else if (wr_ser) begin
                receive_done_flag_q <= pwdata[SER_RX];
            end
            if (tx_done) begin
                transmit_done_flag_q <= 1'b1;
            end else if (wr_ser) begin
                transmit_done_flag_q <= pwdata[SER_TX];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer2_overflow_flag_q  <= 1'b0;
            timer2_pin_event_flag_q <= 1'b0;
            timer2_pin_enable_q     <= 1'b0;
        end else if (clk_en) begin
            if (wr_t2) begin
                timer2_pin_enable_q <= pwdata[T2_EXEN];
            end
            if (t2_rollover) begin
                timer2_overflow_flag_q <= 1'b1;
            end else if (wr_t2) begin
                timer2_overflow_flag_q <= pwdata[T2_TF];
            end
            // third falling-edge input on the timer 2 vector
            if (timer2_pin_enable_q && fall[2]) begin
                timer2_pin_event_flag_q <= 1'b1;
            end else if (wr_t2) begin
                timer2_pin_event_flag_q <= pwdata[T2_EXF];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_mask_q    <= REG_RST;
            priority_level_q <= SRC_RST;
            ev_mask_q        <= SRC_RST;
        end else if (apb_wr) begin
            if (paddr == ENABLE_A) begin
                enable_mask_q <= {pwdata[EN_GLOBAL], 1'b0,
                                  pwdata[NSRC-1:0]};
            end
            if (paddr == PRIORITY_A) begin
                priority_level_q <= pwdata[NSRC-1:0];
            end
            if (paddr == EVMASK_A) begin
                ev_mask_q <= pwdata[NSRC-1:0];
            end
        end
    end

    // global and own enable gate every source
    assign active = src_req & enable_mask_q[NSRC-1:0]
                  & {NSRC{enable_mask_q[EN_GLOBAL]}};

    sic_prio_pick #(.N(NSRC)) u_pick_hi (
        .req   (active & priority_level_q),
        .found (hi_found),
        .idx   (hi_idx)
    );

    sic_prio_pick #(.N(NSRC)) u_pick_lo (
        .req   (active & ~priority_level_q),
        .found (lo_found),
        .idx   (lo_idx)
    );

    // high level wins over low; nothing preempts a high routine
    always_comb begin
        grant      = 1'b0;
        grant_high = 1'b0;
        grant_idx  = '0;
        if (hi_found && !in_svc_q[1]) begin
            grant      = 1'b1;
            grant_high = 1'b1;
            grant_idx  = hi_idx;
        end else if (lo_found && in_svc_q == 2'b00) begin
            grant      = 1'b1;
            grant_idx  = lo_idx;
        end
    end

    // the take cycle still sees stale flags, so the offer drops once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_req_q  <= 1'b0;
            vec_addr_q <= VEC_BASE;
            vec_high_q <= 1'b0;
            sel_idx_q  <= '0;
        end else if (clk_en) begin
            vec_req_q  <= grant & ~take;
            vec_high_q <= grant_high;
            sel_idx_q  <= grant_idx;
            vec_addr_q <= VEC_BASE
                        + VEC_STEP * {{(16-IW){1'b0}}, grant_idx};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_svc_q <= 2'b00;
        end else if (clk_en) begin
            if (take) begin
                in_svc_q[vec_high_q] <= 1'b1;
                if (svc_return && vec_high_q) begin
                    in_svc_q[0] <= 1'b0;
                end
            end else if (svc_return) begin
                if (in_svc_q[1]) begin
                    in_svc_q[1] <= 1'b0;
                end else begin
                    in_svc_q[0] <= 1'b0;
                end
            end
        end
    end

    // either low ext request pin wakes during power_down; the core gates its clock from this
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
        end else if (clk_en) begin
            wake_q <= power_down & ~(&ext_pin);
        end
    end

    assign ev_new = src_req & ~src_prev_q;

    // new request sets a sticky bit; set beats the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_q  <= SRC_RST;
            ev_status_q <= SRC_RST;
            irq_q       <= 1'b0;
        end else if (clk_en) begin
            src_prev_q <= src_req;
            irq_q      <= |(ev_status_q & ev_mask_q);
            if (apb_rd && paddr == EVSTAT_A) begin
                ev_status_q <= (ev_status_q & ~prdata_q[NSRC-1:0])
                             | ev_new;
            end else begin
                ev_status_q <= ev_status_q | ev_new;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            TIMER_CTRL_A: begin
                for (int i = 0; i < 2; i++) begin
                    rd_mux[TC_EDGE0 + TC_STEP*i] = ext_edge_select_q[i];
                    rd_mux[TC_PEND0 + TC_STEP*i] = ext_pending_flag_q[i];
                end
                rd_mux[TC_TF0] = timer0_overflow_flag_q;
                rd_mux[TC_TF1] = timer1_overflow_flag_q;
            end
            SERIAL_A: begin
                rd_mux[SER_RX] = receive_done_flag_q;
                rd_mux[SER_TX] = transmit_done_flag_q;
            end
            TIMER2_A: begin
                rd_mux[T2_EXEN] = timer2_pin_enable_q;
                rd_mux[T2_EXF]  = timer2_pin_event_flag_q;
                rd_mux[T2_TF]   = timer2_overflow_flag_q;
            end
            ENABLE_A: begin
                rd_mux[7:0] = enable_mask_q;
            end
            PRIORITY_A: begin
                rd_mux[NSRC-1:0] = priority_level_q;
            end
            EVSTAT_A: begin
                rd_mux[NSRC-1:0] = ev_status_q;
            end
            EVMASK_A: begin
                rd_mux[NSRC-1:0] = ev_mask_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // no wait state: answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            pready_q <= psel & ~penable & ~pready_q;
            if (psel && !penable) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= ~rd_hit;
            end else if (apb_done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign vec_req  = vec_req_q;
    assign vec_addr = vec_addr_q;
    assign vec_high = vec_high_q;
    assign wake_up  = wake_q;
    assign irq      = irq_q;
endmodule

// File: verif/sic_ctrl_assertions.sv
`timescale 1ns/1ps
module sic_ctrl_assertions (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     clk_en,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [sic_pkg::AW-1:0]   paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     ext_request_pin_0,
    input wire logic                     ext_request_pin_1,
    input wire logic                     timer2_capture_pin,
    input wire logic                     t0_rollover,
    input wire logic                     t1_rollover,
    input wire logic                     t2_rollover,
    input wire logic                     rx_done,
    input wire logic                     tx_done,
    input wire logic                     vec_taken,
    input wire logic                     svc_return,
    input wire logic                     power_down,
    input wire logic                     vec_req,
    input wire logic [15:0]              vec_addr,
    input wire logic                     vec_high,
    input wire logic                     wake_up,
    input wire logic                     irq
);
    import sic_pkg::*;
    logic [7:0] en_q;
    logic       hi_q;
    logic       lo_q;
    wire        en_wr = psel && penable && pready && pwrite && !pslverr
                        && paddr == ENABLE_A && clk_en;
    wire        take = vec_taken && vec_req && clk_en;
    // shadow of the enable register, seen only through committed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_q <= 8'h00;
        else if (en_wr)
            en_q <= pwdata[7:0];
    end
    // in-service shadow: return ends the high routine first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else if (take) begin
            hi_q <= hi_q | vec_high;
            lo_q <= lo_q | !vec_high;
        end else if (svc_return && clk_en) begin
            hi_q <= 1'b0;
            lo_q <= lo_q & hi_q;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_slot: assert property (psel && !penable && clk_en |=> pready)
        else $error("pready missing after setup");
    chk_ready_only: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    chk_vec_gate: assert property ((!en_q[EN_GLOBAL]) [*3] |-> !vec_req)
        else $error("vector offered with global enable clear");
    chk_vec_range: assert property (vec_req |-> vec_addr[2:0] == 3'h3
        && vec_addr <= 16'h002b)
        else $error("vector address off the table");
    chk_take_drop: assert property (take |=> !vec_req)
        else $error("offer stands after take");
    chk_wake_set: assert property (power_down && clk_en
        && !(ext_request_pin_0 && ext_request_pin_1) |=> wake_up)
        else $error("no wake on external request");
    chk_wake_clr: assert property (!power_down && clk_en |=> !wake_up)
        else $error("wake outside power-down");
    chk_high_block: assert property (hi_q |-> !vec_req)
        else $error("offer during high routine");
    chk_low_block: assert property (lo_q && vec_req |-> vec_high)
        else $error("low offer during low routine");
    cov_high_take: cover property (take && vec_high);
    cov_preempt: cover property (lo_q && vec_req);
    cov_wake: cover property (wake_up);
    cov_slverr: cover property (pslverr);
endmodule
bind sic_ctrl sic_ctrl_assertions u_chk (.*);

// File: verif/sic_core_model.sv
`timescale 1ns/1ps
module sic_core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    input  wire logic ret,
    input  wire logic slow,
    input  wire logic vec_req,
    output logic      vec_taken,
    output logic      svc_return
);
    logic       armed_q;
    logic [1:0] wait_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q    <= 1'b0;
            wait_q     <= 2'h0;
            vec_taken  <= 1'b0;
            svc_return <= 1'b0;
        end else begin
            svc_return <= ret;
            if (go)
                armed_q <= 1'b1;
            if (vec_taken) begin
                vec_taken <= 1'b0;
                armed_q   <= 1'b0;
                wait_q    <= 2'h0;
            end else if (armed_q && vec_req) begin
                // a slow core lets the offer stand a few cycles first
                wait_q    <= wait_q + 2'h1;
                vec_taken <= !slow || wait_q == 2'h3;
            end
        end
    end
endmodule

// File: verif/six_source_interrupt_ctrl_tb_top.sv
`timescale 1ns/1ps
module six_source_interrupt_ctrl_tb_top;
    import sic_pkg::*;
    logic          pclk, presetn, clk_en, psel, penable, pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata, prdata;
    logic          pready, pslverr, last_err, power_down, go, ret, slow;
    logic          ext_request_pin_0, ext_request_pin_1, timer2_capture_pin;
    logic          t0_rollover, t1_rollover, t2_rollover, rx_done, tx_done;
    logic          vec_taken, svc_return, vec_req, vec_high, wake_up, irq;
    logic [15:0]   vec_addr;
    int            errors = 0;
    int            total_checks = 0;
    int            cyc = 0;

    sic_ctrl u_dut (.*);
    sic_core_model u_core (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done;
        end
    end

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // idle cycle after each transfer keeps one assignment per time step
    task automatic apb(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        tick(1);
        while (pready !== 1'b1)
            tick(1);
        r = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), e, r);
    endtask
    task automatic ev(input logic [4:0] m);
        {t0_rollover, t1_rollover, t2_rollover, rx_done, tx_done} <= m;
        tick(1);
        {t0_rollover, t1_rollover, t2_rollover, rx_done, tx_done} <= 5'h0;
        tick(3);
    endtask
    task automatic cap_fall;
        timer2_capture_pin <= 1'b0;
        tick(1);
        timer2_capture_pin <= 1'b1;
        tick(3);
    endtask
    task automatic serve(input logic [15:0] e, input logic hi);
        int n = 0;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        while (!(vec_taken === 1'b1 && vec_req === 1'b1) && n < 40) begin
            tick(1);
            n++;
        end
        chk("vec_taken", 1, vec_taken);
        chk("vec_addr", e, vec_addr);
        chk("vec_high", hi, vec_high);
    endtask
    task automatic done_svc;
        ret <= 1'b1;
        tick(1);
        ret <= 1'b0;
        tick(3);
    endtask

    task automatic t_regs;
        rchk(ENABLE_A, 32'h0);
        rchk(PRIORITY_A, 32'h0);
        wr(PRIORITY_A, 32'hff);
        rchk(PRIORITY_A, 32'h3f);
        wr(PRIORITY_A, 32'h0);
        rchk(8'h90, 32'h0);
        chk("pslverr", 1, last_err);
        wr(ENABLE_A, 32'hff);
        rchk(ENABLE_A, 32'hbf);
    endtask
    task automatic t_timers;
        ev(5'b11111);
        rchk(TIMER_CTRL_A, 32'ha0);
        serve(16'h000b, 0);
        rchk(TIMER_CTRL_A, 32'h80);
        done_svc;
        serve(16'h001b, 0);
        rchk(TIMER_CTRL_A, 32'h00);
        done_svc;
        serve(16'h0023, 0);
        done_svc;
        rchk(SERIAL_A, 32'h03);
        serve(16'h0023, 0);
        wr(SERIAL_A, 32'h0);
        done_svc;
        serve(16'h002b, 0);
        rchk(TIMER2_A, 32'h80);
        wr(TIMER2_A, 32'h0);
        done_svc;
        cap_fall;
        rchk(TIMER2_A, 32'h00);
        wr(TIMER2_A, 32'h08);
        cap_fall;
        rchk(TIMER2_A, 32'h48);
        serve(16'h002b, 0);
        wr(TIMER2_A, 32'h0);
        done_svc;
        chk("vec_req", 0, vec_req);
    endtask
    task automatic t_irq;
        rchk(EVSTAT_A, 32'h3a);
        wr(EVMASK_A, 32'h02);
        wr(ENABLE_A, 32'h0a);
        ev(5'b01000);
        chk("irq", 0, irq);
        ev(5'b10000);
        chk("irq", 1, irq);
        chk("vec_req", 0, vec_req);
        rchk(EVSTAT_A, 32'h0a);
        tick(2);
        chk("irq", 0, irq);
        rchk(EVSTAT_A, 32'h00);
        wr(ENABLE_A, 32'h8a);
        serve(16'h000b, 0);
        done_svc;
        serve(16'h001b, 0);
        done_svc;
    endtask
    task automatic t_ext;
        wr(TIMER_CTRL_A, 32'h01);
        wr(ENABLE_A, 32'h85);
        ext_request_pin_0 <= 1'b0;
        tick(1);
        ext_request_pin_0 <= 1'b1;
        tick(3);
        rchk(TIMER_CTRL_A, 32'h03);
        serve(16'h0003, 0);
        rchk(TIMER_CTRL_A, 32'h01);
        done_svc;
        ext_request_pin_1 <= 1'b0;
        tick(3);
        serve(16'h0013, 0);
        rchk(TIMER_CTRL_A, 32'h09);
        ext_request_pin_1 <= 1'b1;
        done_svc;
        chk("vec_req", 0, vec_req);
        wr(ENABLE_A, 32'h0);
        wr(TIMER_CTRL_A, 32'h05);
        power_down <= 1'b1;
        tick(2);
        chk("wake_up", 0, wake_up);
        ext_request_pin_1 <= 1'b0;
        tick(2);
        chk("wake_up", 1, wake_up);
        ext_request_pin_1 <= 1'b1;
        power_down <= 1'b0;
        tick(2);
        rchk(TIMER_CTRL_A, 32'h0d);
        wr(TIMER_CTRL_A, 32'h0);
    endtask
    task automatic t_prio;
        slow <= 1'b1;
        wr(ENABLE_A, 32'h8a);
        wr(PRIORITY_A, 32'h08);
        ev(5'b11000);
        serve(16'h001b, 1);
        tick(3);
        chk("vec_req", 0, vec_req);
        done_svc;
        serve(16'h000b, 0);
        ev(5'b01000);
        serve(16'h001b, 1);
        ev(5'b10000);
        chk("vec_req", 0, vec_req);
        done_svc;
        chk("vec_req", 0, vec_req);
        done_svc;
        serve(16'h000b, 0);
        done_svc;
        // a rollover while frozen must leave no flag behind
        clk_en <= 1'b0;
        ev(5'b10000);
        clk_en <= 1'b1;
        rchk(TIMER_CTRL_A, 32'h00);
        slow <= 1'b0;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, power_down, go, ret, slow} = 8'h0;
        {t0_rollover, t1_rollover, t2_rollover, rx_done, tx_done} = 5'h0;
        {clk_en, ext_request_pin_0, ext_request_pin_1} = 3'h7;
        timer2_capture_pin = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        tick(6);
        presetn <= 1'b1;
        tick(1);
        t_regs;
        t_timers;
        t_irq;
        t_ext;
        t_prio;
        test_done;
    end
endmodule
